// File: hw/btdr_pkg.sv
// Purpose: Shared constants and carrier types of the bus trace debug registers
// Assumes: 8-bit register port, 16-bit CPU address bus, one bus clock
// Notes: Register indices are local to the debug register window
package btdr_pkg;
  // Register indices on the register port
  localparam logic [2:0] IDX_CMP_A_HIGH = 3'h0;
  localparam logic [2:0] IDX_CMP_A_LOW = 3'h1;
  localparam logic [2:0] IDX_CMP_B_HIGH = 3'h2;
  localparam logic [2:0] IDX_CMP_B_LOW = 3'h3;
  localparam logic [2:0] IDX_FIFO_HIGH = 3'h4;
  localparam logic [2:0] IDX_FIFO_LOW = 3'h5;
  localparam logic [2:0] IDX_TRACE_CONTROL = 3'h6;
  localparam logic [2:0] IDX_FORCE_RESET = 3'h7;

  // Control field positions
  localparam int CTL_ENABLE = 7;
  localparam int CTL_ARM = 6;
  localparam int CTL_TAG = 5;
  localparam int CTL_BRK = 4;
  localparam int CTL_DIR_A = 3;
  localparam int CTL_QUAL_A = 2;
  localparam int CTL_DIR_B = 1;
  localparam int CTL_QUAL_B = 0;
  localparam int FORCE_RESET_BIT = 0;

  // Reset values and fixed read values
  localparam logic [7:0] CMP_RESET = 8'h00;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] FORCE_RESET_READ = 8'h00;
  localparam logic [7:0] FIFO_HIGH_EVENT_READ = 8'h00;
  localparam logic [15:0] BKPT_RESET = 16'h0000;
  localparam logic [15:0] FIFO_RESET = 16'h0000;

  // FIFO geometry and valid count
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] COUNT_FULL = 4'h8;
  localparam logic [3:0] COUNT_CLEAR = 4'h0;

  // Serial debug command codes
  typedef enum logic [1:0] {
    CMD_READ_BYTE = 2'h0,
    CMD_WRITE_BYTE = 2'h1,
    cmd_read_breakpoint = 2'h2,
    cmd_write_breakpoint = 2'h3
  } btdr_cmd_op_t;

  // Capture run states, Gray along idle -> armed -> storing
  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_ARMED = 2'b01,
    RUN_STORE = 2'b11
  } btdr_run_t;

  // One CPU bus cycle
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic cycle;
  } btdr_bus_t;

  // Register access from user program
  typedef struct packed {
    logic [2:0] idx;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } btdr_reg_req_t;

  // Command from the serial debug controller
  typedef struct packed {
    btdr_cmd_op_t op;
    logic valid;
    logic [2:0] idx;
    logic [15:0] wdata;
  } btdr_cmd_t;
endpackage

// File: hw/btdr_comparator.sv
// Purpose: One 16-bit address comparator with read/write qualification
// Assumes: Compare value is stable while armed
// Notes: Match is registered, one cycle after the bus cycle
`timescale 1ns/1ps
`default_nettype none
module btdr_comparator
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Compare setup
  input wire logic [15:0] value,
  input wire logic armed,
  input wire logic qualify,
  input wire logic dir_read,
  // CPU bus
  input wire btdr_pkg::btdr_bus_t bus,
  // Result
  output logic match
);
  logic addr_hit;
  logic dir_ok;

  assign addr_hit = (bus.addr == value);
  // Qualifier low means the direction of the cycle is ignored
  assign dir_ok = !qualify || (bus.rd == dir_read);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      match <= 1'b0;
    else
      match <= armed && bus.cycle && addr_hit && dir_ok;
  end
endmodule
`default_nettype wire

// File: hw/btdr_top.sv
// Purpose: Debug register block: comparators, trace FIFO, control, breakpoint, force reset
// Assumes: Trigger mode logic lives outside and reports trigger and store events
// Notes: Serial byte commands take priority over a user access in the same cycle
`timescale 1ns/1ps
`default_nettype none
module btdr_top
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // CPU bus and core status
  input wire btdr_pkg::btdr_bus_t cpu_bus,
  input wire logic [15:0] opcode_fetch_addr,
  input wire logic secure_state,
  // Trigger logic outside this block
  input wire logic trig_hit,
  input wire logic trace_begin,
  input wire logic event_only,
  input wire logic store_req,
  input wire logic [15:0] store_word,
  // User register port
  input wire btdr_pkg::btdr_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Serial debug command port
  input wire btdr_pkg::btdr_cmd_t cmd,
  output logic [15:0] cmd_rdata,
  // Serial breakpoint setup from the status-control register
  input wire logic serial_break_enable,
  input wire logic serial_break_kind,
  output logic bkpt_force,
  output logic bkpt_tag,
  // Outputs to core and system
  output logic match_a,
  output logic match_b,
  output logic break_req,
  output logic break_tag,
  output logic mcu_reset_req,
  output logic capture_run_flag,
  output logic [3:0] fifo_valid_count
);
  logic [15:0] breakpoint_address;
  logic [7:0] cmp_byte [4];
  logic [7:0] trace_control;
  logic [15:0] fifo [btdr_pkg::FIFO_DEPTH];
  typedef btdr_pkg::btdr_run_t btdr_run_t;
  btdr_run_t run_state;
  btdr_run_t next_run_state;

  // Merged register access; the serial side wins a collision
  logic ser_byte;
  logic acc_wr;
  logic acc_rd;
  logic [2:0] acc_idx;
  logic [7:0] acc_wdata;
  logic ctl_write;
  logic armed;
  logic run_done;
  logic fifo_store;
  logic fifo_read_low;
  logic [15:0] store_value;
  logic [7:0] next_ctl;
  logic [1:0] cmp_match;

  assign ser_byte = cmd.valid &&
    (cmd.op == btdr_pkg::CMD_WRITE_BYTE || cmd.op == btdr_pkg::CMD_READ_BYTE);
  assign acc_wr = ser_byte ? (cmd.op == btdr_pkg::CMD_WRITE_BYTE) : reg_req.wr;
  assign acc_rd = ser_byte ? (cmd.op == btdr_pkg::CMD_READ_BYTE) : reg_req.rd;
  assign acc_idx = ser_byte ? cmd.idx : reg_req.idx;
  assign acc_wdata = ser_byte ? cmd.wdata[7:0] : reg_req.wdata;
  assign ctl_write = acc_wr && (acc_idx == btdr_pkg::IDX_TRACE_CONTROL);
  assign armed = (run_state != btdr_pkg::RUN_IDLE);
  assign fifo_read_low = acc_rd && (acc_idx == btdr_pkg::IDX_FIFO_LOW);

  // Control written value; enable cannot rise while secure
  always_comb
  begin
    next_ctl = acc_wdata;
    if (secure_state && !trace_control[btdr_pkg::CTL_ENABLE])
      next_ctl[btdr_pkg::CTL_ENABLE] = 1'b0;
    if (!next_ctl[btdr_pkg::CTL_ENABLE])
      next_ctl[btdr_pkg::CTL_ARM] = 1'b0;
  end

  // Run sequencing; event-only runs are treated as begin traces
  always_comb
  begin
    next_run_state = run_state;
    run_done = 1'b0;
    fifo_store = 1'b0;
    unique case (run_state)
      btdr_pkg::RUN_IDLE:
      begin
        if (ctl_write && next_ctl[btdr_pkg::CTL_ARM])
          next_run_state = btdr_pkg::RUN_ARMED;
      end
      btdr_pkg::RUN_ARMED:
      begin
        if (trace_begin || event_only)
        begin
          if (trig_hit)
            next_run_state = btdr_pkg::RUN_STORE;
        end
        else
        begin
          fifo_store = store_req;
          if (trig_hit)
          begin
            run_done = 1'b1;
            next_run_state = btdr_pkg::RUN_IDLE;
          end
        end
      end
      btdr_pkg::RUN_STORE:
      begin
        fifo_store = store_req && (fifo_valid_count != btdr_pkg::COUNT_FULL);
        if (fifo_valid_count == btdr_pkg::COUNT_FULL)
        begin
          run_done = 1'b1;
          next_run_state = btdr_pkg::RUN_IDLE;
        end
      end
      default:
      begin
        next_run_state = btdr_pkg::RUN_IDLE;
      end
    endcase
    if (ctl_write && !next_ctl[btdr_pkg::CTL_ARM])
    begin
      run_done = 1'b0;
      next_run_state = btdr_pkg::RUN_IDLE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      run_state <= btdr_pkg::RUN_IDLE;
    else
      run_state <= next_run_state;
  end

  // Run flag is registered from the next state, so it shows the current arm state
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      capture_run_flag <= 1'b0;
    else
      capture_run_flag <= (next_run_state != btdr_pkg::RUN_IDLE);
  end

  // Control register; the arm bit follows the run state
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      trace_control <= btdr_pkg::CTL_RESET;
    else if (ctl_write)
    begin
      trace_control <= next_ctl;
      // A run that completes on this edge still drops the arm bit
      if (run_done)
        trace_control[btdr_pkg::CTL_ARM] <= 1'b0;
    end
    else if (run_done)
      trace_control[btdr_pkg::CTL_ARM] <= 1'b0;
    else if (run_state == btdr_pkg::RUN_STORE && next_run_state == btdr_pkg::RUN_IDLE)
      trace_control[btdr_pkg::CTL_ARM] <= 1'b0;
  end

  // Comparator byte registers, locked while armed
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_cmp_byte
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          cmp_byte[gi] <= btdr_pkg::CMP_RESET;
        else if (acc_wr && !armed && acc_idx == 3'(gi))
          cmp_byte[gi] <= acc_wdata;
      end
    end
  endgenerate

  // Two comparators: A from bytes 0/1, B from bytes 2/3
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_cmp
      btdr_comparator u_cmp
      (
        .clk(clk),
        .rst_n(rst_n),
        .value({cmp_byte[2 * gi], cmp_byte[2 * gi + 1]}),
        .armed(armed),
        .qualify(trace_control[btdr_pkg::CTL_QUAL_A - 2 * gi]),
        .dir_read(trace_control[btdr_pkg::CTL_DIR_A - 2 * gi]),
        .bus(cpu_bus),
        .match(cmp_match[gi])
      );
    end
  endgenerate

  assign match_a = cmp_match[0];
  assign match_b = cmp_match[1];

  // Event-only captures keep the high half clear
  assign store_value = event_only ? {8'h00, store_word[7:0]} : store_word;

  // Trace FIFO: shift toward slot 0, new words enter the last slot
  generate
    for (gi = 0; gi < btdr_pkg::FIFO_DEPTH; gi++)
    begin : g_fifo
      always_ff @(posedge clk)
      begin
        if (!rst_n)
          fifo[gi] <= btdr_pkg::FIFO_RESET;
        else if (fifo_store || (fifo_read_low && !armed))
        begin
          if (gi == btdr_pkg::FIFO_DEPTH - 1)
            fifo[gi] <= fifo_store ? store_value : opcode_fetch_addr;
          else
            fifo[gi] <= fifo[(gi + 1) % btdr_pkg::FIFO_DEPTH];
        end
      end
    end
  endgenerate

  // Valid word count: cleared at run start, saturates, never decremented by reads
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      fifo_valid_count <= btdr_pkg::COUNT_CLEAR;
    else if (run_state == btdr_pkg::RUN_IDLE && next_run_state == btdr_pkg::RUN_ARMED)
      fifo_valid_count <= btdr_pkg::COUNT_CLEAR;
    else if (fifo_store && fifo_valid_count != btdr_pkg::COUNT_FULL)
      fifo_valid_count <= fifo_valid_count + 4'h1;
  end

  // Break request at run completion; kind from the tag bit
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      break_req <= 1'b0;
      break_tag <= 1'b0;
    end
    else
    begin
      break_req <= run_done && trace_control[btdr_pkg::CTL_BRK];
      break_tag <= trace_control[btdr_pkg::CTL_TAG] && trace_control[btdr_pkg::CTL_BRK];
    end
  end

  // User read data; FIFO low reads slot 0, high reads slot 0 or zero in event-only mode
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (acc_rd)
    begin
      unique case (acc_idx)
        btdr_pkg::IDX_CMP_A_HIGH,
        btdr_pkg::IDX_CMP_A_LOW,
        btdr_pkg::IDX_CMP_B_HIGH,
        btdr_pkg::IDX_CMP_B_LOW:
          reg_rdata <= cmp_byte[acc_idx[1:0]];
        btdr_pkg::IDX_FIFO_HIGH:
          reg_rdata <= event_only ? btdr_pkg::FIFO_HIGH_EVENT_READ : fifo[0][15:8];
        btdr_pkg::IDX_FIFO_LOW:
          reg_rdata <= fifo[0][7:0];
        btdr_pkg::IDX_TRACE_CONTROL:
          reg_rdata <= trace_control;
        btdr_pkg::IDX_FORCE_RESET:
          reg_rdata <= btdr_pkg::FORCE_RESET_READ;
      endcase
    end
  end

  // Breakpoint address, reached only through serial commands
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      breakpoint_address <= btdr_pkg::BKPT_RESET;
    else if (cmd.valid && cmd.op == btdr_pkg::cmd_write_breakpoint)
      breakpoint_address <= cmd.wdata;
  end

  // Serial read data mirrors byte reads in the low half
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cmd_rdata <= 16'h0000;
    else if (cmd.valid && cmd.op == btdr_pkg::cmd_read_breakpoint)
      cmd_rdata <= breakpoint_address;
    else if (cmd.valid && cmd.op == btdr_pkg::CMD_READ_BYTE)
    begin
      unique case (cmd.idx)
        btdr_pkg::IDX_FIFO_HIGH:
          cmd_rdata <= {8'h00, event_only ? btdr_pkg::FIFO_HIGH_EVENT_READ : fifo[0][15:8]};
        btdr_pkg::IDX_FIFO_LOW:
          cmd_rdata <= {8'h00, fifo[0][7:0]};
        btdr_pkg::IDX_TRACE_CONTROL:
          cmd_rdata <= {8'h00, trace_control};
        btdr_pkg::IDX_FORCE_RESET:
          cmd_rdata <= {8'h00, btdr_pkg::FORCE_RESET_READ};
        default:
          cmd_rdata <= {8'h00, cmp_byte[cmd.idx[1:0]]};
      endcase
    end
  end

  // Serial breakpoint match; ignored entirely when not enabled
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      bkpt_force <= 1'b0;
      bkpt_tag <= 1'b0;
    end
    else
    begin
      bkpt_force <= serial_break_enable && serial_break_kind && cpu_bus.cycle &&
        cpu_bus.addr == breakpoint_address;
      bkpt_tag <= serial_break_enable && !serial_break_kind && cpu_bus.cycle &&
        cpu_bus.addr == breakpoint_address;
    end
  end

  // Force reset: only a serial byte write counts, user writes never reach it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mcu_reset_req <= 1'b0;
    else
      mcu_reset_req <= cmd.valid && cmd.op == btdr_pkg::CMD_WRITE_BYTE &&
        cmd.idx == btdr_pkg::IDX_FORCE_RESET && cmd.wdata[btdr_pkg::FORCE_RESET_BIT];
  end
endmodule
`default_nettype wire

// File: bench/btdr_cpu_model.sv
// Purpose: CPU bus and opcode fetch model facing btdr_top
// Assumes: Bench raises go for one bus cycle at a time
// Notes: Idle address lines toggle so stale values never match
`timescale 1ns/1ps
`default_nettype none
module btdr_cpu_model
(
  // Clock
  input wire logic clk,
  // Cycle request
  input wire logic go,
  input wire logic [15:0] addr,
  input wire logic rd,
  input wire logic [15:0] fetch,
  // Toward the debug block
  output btdr_pkg::btdr_bus_t bus,
  output logic [15:0] opcode_fetch_addr
);
  logic [15:0] last = 16'h0000;
  always_ff @(posedge clk) last <= bus.addr;
  always_comb bus = go ? {addr, rd, 1'b1} : {~last, ~last[0], 1'b0};
  assign opcode_fetch_addr = fetch;
endmodule
`default_nettype wire

// File: bench/btdr_checker.sv
// Purpose: Port assertions of btdr_top
// Assumes: Single clock, synchronous reset
// Notes: Bound to every btdr_top instance
`timescale 1ns/1ps
`default_nettype none
module btdr_checker
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Inputs watched
  input wire btdr_pkg::btdr_bus_t cpu_bus,
  input wire btdr_pkg::btdr_reg_req_t reg_req,
  input wire btdr_pkg::btdr_cmd_t cmd,
  input wire logic event_only,
  input wire logic serial_break_enable,
  input wire logic serial_break_kind,
  // Outputs watched
  input wire logic [7:0] reg_rdata,
  input wire logic bkpt_force,
  input wire logic match_a,
  input wire logic match_b,
  input wire logic break_req,
  input wire logic mcu_reset_req,
  input wire logic capture_run_flag,
  input wire logic [3:0] fifo_valid_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic urd;
  logic srst;
  // Serial byte commands win, so a user read only counts alone
  assign urd = reg_req.rd && !cmd.valid;
  assign srst = cmd.valid && cmd.op == btdr_pkg::CMD_WRITE_BYTE && cmd.idx == 3'h7
    && cmd.wdata[0];
  a_serial_reset_pulse: assert property (
    srst |=> mcu_reset_req ##1 !mcu_reset_req) else $error("reset pulse wrong");
  a_reset_only_serial: assert property (
    mcu_reset_req |-> $past(srst)) else $error("reset without serial write");
  a_reset_reads_zero: assert property (
    urd && reg_req.idx == 3'h7 |=> reg_rdata == 8'h00) else $error("force reset read");
  a_event_high_zero: assert property (
    urd && reg_req.idx == 3'h4 && event_only |=> reg_rdata == 8'h00)
    else $error("event high byte");
  a_count_steps: assert property (
    $changed(fifo_valid_count) |-> fifo_valid_count == 4'h0
    || fifo_valid_count == $past(fifo_valid_count) + 4'h1) else $error("count step");
  a_break_one_pulse: assert property (
    break_req |-> !capture_run_flag ##1 !break_req) else $error("break pulse");
  a_match_a_armed: assert property (
    match_a |-> $past(capture_run_flag && cpu_bus.cycle)) else $error("match a");
  a_match_b_armed: assert property (
    match_b |-> $past(capture_run_flag && cpu_bus.cycle)) else $error("match b");
  a_bkpt_force_cause: assert property (
    bkpt_force |-> $past(serial_break_enable && serial_break_kind && cpu_bus.cycle))
    else $error("breakpoint force");
  c_break: cover property (break_req);
  c_reset: cover property (mcu_reset_req);
  c_full: cover property (fifo_valid_count == 4'h8);
endmodule
bind btdr_top btdr_checker btdr_checker_inst (.clk(clk), .rst_n(rst_n),
  .cpu_bus(cpu_bus), .reg_req(reg_req), .cmd(cmd), .event_only(event_only),
  .serial_break_enable(serial_break_enable), .serial_break_kind(serial_break_kind),
  .reg_rdata(reg_rdata), .bkpt_force(bkpt_force), .match_a(match_a),
  .match_b(match_b), .break_req(break_req), .mcu_reset_req(mcu_reset_req),
  .capture_run_flag(capture_run_flag), .fifo_valid_count(fifo_valid_count));
`default_nettype wire

// File: bench/tb.sv
// Purpose: Self-checking bench of btdr_top
// Assumes: Inputs change on the falling edge
// Notes: Random data from a fixed-seed shift register
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, rst_n = 0, go = 0, brd = 0, sec = 0, trig = 0, tbeg = 0;
  logic evo = 0, sreq = 0, sbe = 0, sbk = 0;
  logic [15:0] baddr = 0, fetch = 0, sword = 0, crdata, ofa, bp;
  logic [7:0] rdata, d, hi;
  logic bf, bt, ma, mb, brq, btg, mrr, flag;
  logic [3:0] cnt;
  btdr_pkg::btdr_bus_t bus;
  btdr_pkg::btdr_reg_req_t rq = '0;
  btdr_pkg::btdr_cmd_t cmd = '0;
  logic [31:0] seed = 32'hfb82b8dc;
  logic [7:0] v [4];
  logic [15:0] w [16];
  int failures = 0, n_tests = 0, nbrk = 0, cyc = 0, n;
  always #50 clk = ~clk;
  btdr_cpu_model btdr_cpu_model_inst (.clk(clk), .go(go), .addr(baddr), .rd(brd),
    .fetch(fetch), .bus(bus), .opcode_fetch_addr(ofa));
  btdr_top btdr_top_inst (.clk(clk), .rst_n(rst_n), .cpu_bus(bus),
    .opcode_fetch_addr(ofa), .secure_state(sec), .trig_hit(trig), .trace_begin(tbeg),
    .event_only(evo), .store_req(sreq), .store_word(sword), .reg_req(rq),
    .reg_rdata(rdata), .cmd(cmd), .cmd_rdata(crdata), .serial_break_enable(sbe),
    .serial_break_kind(sbk), .bkpt_force(bf), .bkpt_tag(bt), .match_a(ma),
    .match_b(mb), .break_req(brq), .break_tag(btg), .mcu_reset_req(mrr),
    .capture_run_flag(flag), .fifo_valid_count(cnt));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Qualified comparators match only when direction agrees
  function automatic logic exp_match(input logic qual, input logic dir, input logic r);
    return !qual || dir == r;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [2:0] i, input logic [7:0] dd);
    @(negedge clk);
    rq = '{i, 1'b1, 1'b0, dd};
    @(negedge clk);
    rq.wr = 0;
  endtask
  task automatic reg_rd(input logic [2:0] i, output logic [7:0] dd);
    @(negedge clk);
    rq.idx = i;
    rq.rd = 1;
    @(negedge clk);
    rq.rd = 0;
    dd = rdata;
  endtask
  task automatic ser(input btdr_pkg::btdr_cmd_op_t op, input logic [2:0] i,
    input logic [15:0] wd);
    @(negedge clk);
    cmd = '{op, 1'b1, i, wd};
    @(negedge clk);
    cmd.valid = 0;
  endtask
  task automatic cyc_at(input logic [15:0] a, input logic r);
    @(negedge clk);
    baddr = a;
    brd = r;
    go = 1;
    @(negedge clk);
    go = 0;
  endtask
  // Trigger pulse when s is 0, stored word when s is 1
  task automatic ev(input logic s);
    @(negedge clk);
    seed = lfsr(seed);
    trig = !s;
    sreq = s;
    sword = seed[15:0];
    @(negedge clk);
    trig = 0;
    sreq = 0;
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Cut a hang short; the whole run needs a few hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (brq === 1'b1)
      nbrk++;
    if (cyc == 20000)
    begin
      failures++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    for (int i = 0; i < 4; i++)
    begin
      reg_rd(i[2:0], d);
      chk(d, 8'h00);
      seed = lfsr(seed);
      v[i] = seed[7:0];
      reg_wr(i[2:0], v[i]);
    end
    reg_rd(3'h6, d);
    chk(d, 8'h00);
    reg_wr(3'h6, 8'hc0);
    chk(flag, 1);
    chk(cnt, 0);
    for (int i = 0; i < 4; i++)
    begin
      reg_wr(i[2:0], ~v[i]);
      reg_rd(i[2:0], d);
      chk(d, v[i]);
    end
    reg_rd(3'h6, d);
    chk(d, 8'hc0);
    for (int q = 0; q < 16; q++)
    begin
      reg_wr(3'h6, 8'hc0 | q[7:0]);
      for (int r = 0; r < 2; r++)
      begin
        cyc_at({v[0], v[1]}, r[0]);
        chk(ma, exp_match(q[2], q[3], r[0]));
        cyc_at({v[2], v[3]}, r[0]);
        chk(mb, exp_match(q[0], q[1], r[0]));
      end
    end
    reg_wr(3'h6, 8'h80);
    chk(flag, 0);
    // End trace then begin trace, both with break requests
    for (int m = 0; m < 2; m++)
    begin
      tbeg = m[0];
      seed = lfsr(seed);
      n = m ? 8 : seed[2:0] % 7 + 1;
      reg_wr(3'h6, 8'hd0);
      if (m)
        ev(0);
      for (int j = 0; j < n; j++)
      begin
        ev(1);
        w[j] = sword;
      end
      if (!m)
        reg_rd(3'h5, d);
      if (!m)
        ev(0);
      for (int k = 0; k < 10 && flag !== 1'b0; k++)
        @(negedge clk);
      repeat (2) @(negedge clk);
      chk(flag, 0);
      chk(cnt, n);
      chk(nbrk, m + 1);
      for (int k = 0; k < 8; k++)
      begin
        reg_rd(3'h4, hi);
        reg_rd(3'h5, d);
        if (k >= 8 - n)
          chk({hi, d}, w[k - 8 + n]);
      end
    end
    // Profiling: each read lands eight reads later
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      fetch = seed[15:0];
      w[i] = fetch;
      if (i == 10)
        reg_wr(3'h5, 8'h5a);
      reg_rd(3'h4, hi);
      reg_rd(3'h5, d);
      if (i > 7)
        chk({hi, d}, w[i - 8]);
    end
    // Event-only run: begin behaviour, only the low byte is kept
    evo = 1;
    reg_rd(3'h4, d);
    chk(d, 8'h00);
    reg_wr(3'h6, 8'hc0);
    ev(0);
    for (int j = 0; j < 8; j++)
    begin
      ev(1);
      w[j] = sword;
    end
    repeat (2) @(negedge clk);
    chk(flag, 0);
    chk(cnt, 8);
    evo = 0;
    for (int k = 0; k < 8; k++)
    begin
      reg_rd(3'h4, hi);
      reg_rd(3'h5, d);
      chk({hi, d}, {8'h00, w[k][7:0]});
    end
    reg_wr(3'h7, 8'h01);
    chk(mrr, 0);
    reg_rd(3'h7, d);
    chk(d, 8'h00);
    ser(btdr_pkg::CMD_WRITE_BYTE, 3'h7, 16'h0001);
    chk(mrr, 1);
    seed = lfsr(seed);
    bp = seed[15:0];
    ser(btdr_pkg::cmd_write_breakpoint, 3'h0, bp);
    ser(btdr_pkg::cmd_read_breakpoint, 3'h0, 16'h0000);
    chk(crdata, bp);
    sbe = 1;
    sbk = 1;
    cyc_at(bp, 1'b0);
    chk(bf, 1);
    chk(bt, 0);
    sbk = 0;
    cyc_at(bp, 1'b1);
    chk({bf, bt}, 2'b01);
    sbe = 0;
    reg_wr(3'h6, 8'h30);
    @(negedge clk);
    chk(btg, 1);
    reg_wr(3'h6, 8'h20);
    @(negedge clk);
    chk(btg, 0);
    sec = 1;
    reg_wr(3'h6, 8'ha0);
    reg_rd(3'h6, d);
    chk(d, 8'h20);
    sec = 0;
    ser(btdr_pkg::CMD_READ_BYTE, 3'h6, 16'h0000);
    chk(crdata, 16'h0020);
    print_verdict;
  end
endmodule
`default_nettype wire
